// File: oss_pkg.sv
// Constants and types for the oscillator source selection block
// Functional notes
// - Instruction clock is selected clock divided by two
// - Power-on source from mode and source config
// - Unprogrammed config starts on divided fast RC
// - Range config tunes external clock, default high
// - Switching enabled only when upper config bit 0
// - Fail-safe monitor enabled only with config 00
// - Internal and secondary source codes per mode
// - Primary codes 011/010, modes 10/01 crystal kinds, 00 external clock
// - Current source read-only at bits 14 to 12
// - Both source fields share one encoding
// - Requested source read/write, reset from config
// - Freeze bit software set-only, resets to 0
// - Clock-fail flag hardware-set, software-clear, resets 0
// - Lock reads 0 during switch or non-PLL mode
// - Drive bit ignored with digital secondary input
// - Config bit selects secondary oscillator power type
// - Only primary and fast RC use PLL
// - Fast RC divided by programmable postscaler
// - Config bit chooses output pin function
// - Trim register fine-tunes fast RC, approximate
// - Unimplemented control bits read as zero
// - Switch-go starts switch, cleared on completion
// - Switching disabled holds go at zero
// - Wait start-up, lock, then ten clocks
// - Freeze with monitor enabled locks selections
package oss_pkg;
  // ==========================================================
  // Register map (byte offsets on the register bus)
  localparam logic [7:0] OFS_OSC_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CLOCK_DIVIDER = 8'h04;
  localparam logic [7:0] OFS_FAST_RC_TRIM = 8'h08;
  localparam logic [7:0] OFS_CONFIG_VIEW = 8'h0C;
  // ==========================================================
  // Control register fields
  localparam int CUR_LSB = 12;
  localparam int REQ_LSB = 8;
  localparam int FREEZE_BIT = 7;
  localparam int LOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int DRIVE_BIT = 2;
  localparam int SEC_EN_BIT = 1;
  localparam int GO_BIT = 0;
  localparam int DIV_LSB = 8;
  // ==========================================================
  // Source encoding shared by current and requested fields
  localparam logic [2:0] SRC_FAST_RC_DIVIDED = 3'h7;
  localparam logic [2:0] SRC_FAST_RC_500K_DIVIDED = 3'h6;
  localparam logic [2:0] SRC_LOW_POWER_RC = 3'h5;
  localparam logic [2:0] SRC_SECONDARY = 3'h4;
  localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] SRC_PRIMARY = 3'h2;
  localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] SRC_FAST_RC = 3'h0;
  // Primary mode encoding
  localparam logic [1:0] PM_INTERNAL = 2'h3;
  localparam logic [1:0] PM_HIGH_SPEED_CRYSTAL = 2'h2;
  localparam logic [1:0] PM_STD_CRYSTAL = 2'h1;
  localparam logic [1:0] PM_EXT_CLOCK = 2'h0;
  // ==========================================================
  // Reset values and timing
  localparam logic [2:0] DIV_RESET = 3'h1;
  localparam logic [5:0] TRIM_RESET = 6'h00;
  localparam logic [3:0] SETTLE_CYCLES = 4'hA;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SW_IDLE, SW_WAIT_START, SW_WAIT_TEN} oss_sw_state_t;
endpackage : oss_pkg

// File: oss_top.sv
// Oscillator source selection with AXI4-Lite control registers
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module oss_top #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] primary_mode_config,
  input wire logic [2:0] initial_source_config,
  input wire logic [1:0] ext_clock_range_config,
  input wire logic [1:0] switch_monitor_config,
  input wire logic secondary_power_type_config,
  input wire logic secondary_source_config,
  input wire logic osc_out_function_config,
  input wire logic osc_tick,
  input wire logic new_src_tick,
  input wire logic new_src_ready,
  input wire logic pll_locked,
  input wire logic clock_failure,
  output logic [2:0] active_source,
  output logic [2:0] starting_source,
  output logic [1:0] primary_kind,
  output logic pll_enable,
  output logic fosc_tick,
  output logic instr_tick,
  output logic secondary_enable,
  output logic secondary_high_power,
  output logic [1:0] ext_clock_range,
  output logic [5:0] fast_rc_trim,
  output logic osc_out_pin_o,
  output logic osc_out_pin_oe
);
  import oss_pkg::*;

  typedef struct packed {
    logic aw_hold;
    logic [ADDR_W-1:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] pm;
    logic [2:0] init_src;
    logic [1:0] range;
    logic [1:0] swmon;
    logic sec_type;
    logic sec_src;
    logic out_fn;
    logic [2:0] cur;
    logic [2:0] req;
    logic freeze;
    logic fail;
    logic drive;
    logic sec_en;
    logic go;
    logic [2:0] rcdiv;
    logic [5:0] trim;
    oss_sw_state_t sw;
    logic [3:0] settle;
    logic [7:0] div_cnt;
    logic div_tick;
    logic phase;
    logic instr;
    logic out_lvl;
  } oss_state_t;

  oss_state_t st_r;
  oss_state_t st_nxt;
  logic sw_enabled;
  logic monitor_on;
  logic frozen;
  logic cur_uses_pll;
  logic cur_divided;
  logic lock_bit;
  logic [7:0] div_term;
  logic [15:0] ctrl_word;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic wr_fire;

  // ==========================================================
  // Decoded configuration
  assign sw_enabled = ~st_r.swmon[1];
  assign monitor_on = (st_r.swmon == 2'h0);
  assign frozen = st_r.freeze & monitor_on;
  // Only these two codes route through the multiplier
  assign cur_uses_pll = (st_r.cur == SRC_PRIMARY_PLL) || (st_r.cur == SRC_FAST_RC_PLL);
  assign cur_divided = (st_r.cur == SRC_FAST_RC_DIVIDED) || (st_r.cur == SRC_FAST_RC_500K_DIVIDED)
                       || (st_r.cur == SRC_FAST_RC_PLL);
  assign lock_bit = pll_locked & cur_uses_pll & (st_r.sw == SW_IDLE);

  // Postscaler ratios 1,2,4,...,64 then 256
  always_comb
  begin
    case (st_r.rcdiv)
      3'h0: div_term = 8'h00;
      3'h1: div_term = 8'h01;
      3'h2: div_term = 8'h03;
      3'h3: div_term = 8'h07;
      3'h4: div_term = 8'h0F;
      3'h5: div_term = 8'h1F;
      3'h6: div_term = 8'h3F;
      default: div_term = 8'hFF;
    endcase
  end

  // ==========================================================
  // Register read view
  always_comb
  begin
    ctrl_word = 16'h0000;
    ctrl_word[CUR_LSB +: 3] = st_r.cur;
    ctrl_word[REQ_LSB +: 3] = st_r.req;
    ctrl_word[FREEZE_BIT] = st_r.freeze;
    ctrl_word[LOCK_BIT] = lock_bit;
    ctrl_word[FAIL_BIT] = st_r.fail;
    ctrl_word[DRIVE_BIT] = st_r.drive;
    ctrl_word[SEC_EN_BIT] = st_r.sec_en;
    ctrl_word[GO_BIT] = st_r.go;
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr[7:0] == OFS_OSC_CONTROL)
      rd_word[15:0] = ctrl_word;
    else if (s_axi_araddr[7:0] == OFS_CLOCK_DIVIDER)
      rd_word[DIV_LSB +: 3] = st_r.rcdiv;
    else if (s_axi_araddr[7:0] == OFS_FAST_RC_TRIM)
      rd_word[5:0] = st_r.trim;
    else if (s_axi_araddr[7:0] == OFS_CONFIG_VIEW)
      rd_word[11:0] = {st_r.out_fn, st_r.sec_src, st_r.sec_type, st_r.swmon, st_r.range,
                       st_r.init_src, st_r.pm};
    else
      rd_hit = 1'b0;
  end

  assign wr_fire = st_r.aw_hold & st_r.w_hold & ~st_r.bvalid;
  assign wr_hit = (st_r.aw_addr[7:0] == OFS_OSC_CONTROL) || (st_r.aw_addr[7:0] == OFS_CLOCK_DIVIDER)
                  || (st_r.aw_addr[7:0] == OFS_FAST_RC_TRIM) || (st_r.aw_addr[7:0] == OFS_CONFIG_VIEW);

  // ==========================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    // Bus write channels: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_nxt.aw_hold = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_nxt.w_hold = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      st_nxt.aw_hold = 1'b0;
      st_nxt.w_hold = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_r.bvalid && s_axi_bready)
      st_nxt.bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word;
      st_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_r.rvalid && s_axi_rready)
      st_nxt.rvalid = 1'b0;

    // Register writes; each byte lane is gated by its strobe
    if (wr_fire && (st_r.aw_addr[7:0] == OFS_OSC_CONTROL))
    begin
      // Requested source is ignored while switching is off or frozen
      if (st_r.w_strb[1] && sw_enabled && !frozen)
        st_nxt.req = st_r.w_data[REQ_LSB +: 3];
      if (st_r.w_strb[0])
      begin
        if (st_r.w_data[FREEZE_BIT])
          st_nxt.freeze = 1'b1;
        if (!st_r.w_data[FAIL_BIT])
          st_nxt.fail = 1'b0;
        st_nxt.drive = st_r.w_data[DRIVE_BIT];
        st_nxt.sec_en = st_r.w_data[SEC_EN_BIT];
        if (st_r.w_data[GO_BIT] && sw_enabled && !frozen)
          st_nxt.go = 1'b1;
      end
    end
    if (wr_fire && (st_r.aw_addr[7:0] == OFS_CLOCK_DIVIDER) && st_r.w_strb[1])
      st_nxt.rcdiv = st_r.w_data[DIV_LSB +: 3];
    if (wr_fire && (st_r.aw_addr[7:0] == OFS_FAST_RC_TRIM) && st_r.w_strb[0])
      st_nxt.trim = st_r.w_data[5:0];

    // Switch sequencer
    case (st_r.sw)
      SW_IDLE:
      begin
        if (st_r.go && (st_r.req == st_r.cur))
          st_nxt.go = 1'b0;
        else if (st_r.go)
        begin
          st_nxt.sw = SW_WAIT_START;
          st_nxt.fail = 1'b0;
        end
      end
      SW_WAIT_START:
      begin
        // New source must be running, and locked when it uses the PLL
        if (new_src_ready && (pll_locked || !((st_r.req == SRC_PRIMARY_PLL)
            || (st_r.req == SRC_FAST_RC_PLL))))
        begin
          st_nxt.sw = SW_WAIT_TEN;
          st_nxt.settle = 4'h0;
        end
      end
      SW_WAIT_TEN:
      begin
        if (new_src_tick)
          st_nxt.settle = st_r.settle + 4'h1;
        if (new_src_tick && (st_r.settle == SETTLE_CYCLES - 4'h1))
        begin
          st_nxt.cur = st_r.req;
          st_nxt.go = 1'b0;
          st_nxt.sw = SW_IDLE;
        end
      end
      default: st_nxt.sw = SW_IDLE;
    endcase
    if (!sw_enabled)
      st_nxt.go = 1'b0;
    // A failure reported in the same cycle as a clear still lands
    if (clock_failure && monitor_on)
      st_nxt.fail = 1'b1;

    // Clock path: postscaler on the divided and PLL fast RC sources (not plain fast RC), then divide by two
    st_nxt.div_tick = 1'b0;
    if (osc_tick)
    begin
      // A ratio lowered below the running count must not let the counter wrap
      if (!cur_divided || (st_r.div_cnt >= div_term))
      begin
        st_nxt.div_cnt = 8'h00;
        st_nxt.div_tick = 1'b1;
      end
      else
        st_nxt.div_cnt = st_r.div_cnt + 8'h01;
    end
    st_nxt.instr = 1'b0;
    if (st_r.div_tick)
    begin
      st_nxt.phase = ~st_r.phase;
      st_nxt.instr = st_r.phase;
      // Toggling per processor tick gives the pin one period per instruction cycle
      st_nxt.out_lvl = ~st_r.out_lvl;
    end

    // Synchronous reset catches the configuration straps
    if (sys_rst)
    begin
      st_nxt = '0;
      st_nxt.sw = SW_IDLE;
      st_nxt.bresp = RESP_OKAY;
      st_nxt.rresp = RESP_OKAY;
      st_nxt.pm = primary_mode_config;
      st_nxt.init_src = initial_source_config;
      st_nxt.range = ext_clock_range_config;
      st_nxt.swmon = switch_monitor_config;
      st_nxt.sec_type = secondary_power_type_config;
      st_nxt.sec_src = secondary_source_config;
      st_nxt.out_fn = osc_out_function_config;
      st_nxt.cur = initial_source_config;
      st_nxt.req = initial_source_config;
      st_nxt.rcdiv = DIV_RESET;
      st_nxt.trim = TRIM_RESET;
    end
  end

  always_ff @(posedge clk)
  begin
    st_r <= st_nxt;
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = ~st_r.aw_hold & ~st_r.bvalid;
  assign s_axi_wready = ~st_r.w_hold & ~st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = ~st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign active_source = st_r.cur;
  assign starting_source = st_r.init_src;
  // Primary submode is fixed by configuration and never switched
  assign primary_kind = st_r.pm;
  assign pll_enable = cur_uses_pll;
  assign fosc_tick = st_r.div_tick;
  assign instr_tick = st_r.instr;
  assign secondary_enable = st_r.sec_en;
  // Digital secondary input ignores the drive bit
  assign secondary_high_power = st_r.sec_src & (st_r.drive | st_r.sec_type);
  assign ext_clock_range = st_r.range;
  assign fast_rc_trim = st_r.trim;
  // Crystal modes need the pin for the resonator, so clock out is refused there
  assign osc_out_pin_oe = st_r.out_fn & ((st_r.pm == PM_EXT_CLOCK) || (st_r.pm == PM_INTERNAL));
  assign osc_out_pin_o = st_r.out_lvl & osc_out_pin_oe;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_cur_at_done;
    !$stable(st_r.cur) |-> $past(st_r.sw == SW_WAIT_TEN) && $past(new_src_tick);
  endproperty
  a_cur_at_done: assert property (p_cur_at_done) else $error("current source moved early");

  property p_go_off;
    st_r.swmon[1] |-> !st_r.go;
  endproperty
  a_go_off: assert property (p_go_off) else $error("go set with switching disabled");

  property p_lock_zero;
    (st_r.sw != SW_IDLE) || !cur_uses_pll |-> !ctrl_word[LOCK_BIT];
  endproperty
  a_lock_zero: assert property (p_lock_zero) else $error("lock shown during switch");

  property p_fail_set;
    clock_failure && monitor_on |=> st_r.fail;
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("clock fail not flagged");

  property p_freeze_sticky;
    st_r.freeze && !sys_rst |=> st_r.freeze;
  endproperty
  a_freeze_sticky: assert property (p_freeze_sticky) else $error("freeze bit cleared");

  property p_redundant;
    (st_r.sw == SW_IDLE) && st_r.go && (st_r.req == st_r.cur) |=> !st_r.go && $stable(st_r.cur);
  endproperty
  a_redundant: assert property (p_redundant) else $error("redundant switch not aborted");

  property p_instr_half;
    instr_tick |-> $past(st_r.phase) && $past(st_r.div_tick);
  endproperty
  a_instr_half: assert property (p_instr_half) else $error("instruction tick not halved");

  property p_pll_route;
    pll_enable |-> (active_source == SRC_PRIMARY_PLL) || (active_source == SRC_FAST_RC_PLL);
  endproperty
  a_pll_route: assert property (p_pll_route) else $error("pll on wrong source");

  property p_frozen_req;
    frozen && (st_r.sw == SW_IDLE) |=> $stable(st_r.req);
  endproperty
  a_frozen_req: assert property (p_frozen_req) else $error("request changed while frozen");

  property p_settle_wait;
    (st_r.sw == SW_WAIT_START) ##1 (st_r.sw == SW_WAIT_TEN) |-> $stable(st_r.cur);
  endproperty
  a_settle_wait: assert property (p_settle_wait) else $error("switched before settle count");
endmodule : oss_top

// File: oss_osc_model.sv
// Behavioural oscillator partner: start-up, PLL lock, new-clock ticks and failure
`timescale 1ns/1ps
module oss_osc_model #(
  parameter int START_DLY = 4,
  parameter int LOCK_DLY = 6
) (
  input wire logic clk,
  input wire logic run,
  input wire logic lock_en,
  input wire logic fail,
  output logic osc_tick,
  output logic new_src_tick,
  output logic new_src_ready,
  output logic pll_locked,
  output logic clock_failure
);
  logic [7:0] st_cnt = 8'h00;
  logic [7:0] lk_cnt = 8'h00;
  logic [1:0] ph3 = 2'h0;
  logic ph2 = 1'b0;
  // ==========================================================
  // Counters
  always @(posedge clk)
  begin
    ph2 <= ~ph2;
    ph3 <= (ph3 == 2'h2) ? 2'h0 : ph3 + 2'h1;
    st_cnt <= !run ? 8'h00 : (st_cnt < 8'(START_DLY)) ? st_cnt + 8'h01 : st_cnt;
    lk_cnt <= !lock_en ? 8'h00 : (lk_cnt < 8'(LOCK_DLY)) ? lk_cnt + 8'h01 : lk_cnt;
  end
  assign osc_tick = ph2;
  // New clock stands still until it has started
  assign new_src_ready = (st_cnt == 8'(START_DLY));
  assign new_src_tick = new_src_ready && (ph3 == 2'h0);
  assign pll_locked = (lk_cnt == 8'(LOCK_DLY));
  assign clock_failure = fail;
endmodule : oss_osc_model

// File: oss_top_tb.sv
// Self-checking testbench for the oscillator source selection block
`timescale 1ns/1ps
module oss_top_tb;
  import oss_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [1:0] pm = PM_INTERNAL, swmon = 2'h0, range_cfg = 2'h3;
  logic [2:0] init_src = 3'h7;
  logic run = 1'b0, lock_en = 1'b0, fail = 1'b0;
  logic osc_tick, new_src_tick, new_src_ready, pll_locked, clock_failure;
  logic [2:0] active_source, starting_source;
  logic [1:0] primary_kind, ext_clock_range;
  logic pll_enable, fosc_tick, instr_tick, secondary_enable, oe, hp, pin_o;
  logic pin_q = 1'b0, sec_src = 1'b1;
  logic [5:0] trim;
  logic [31:0] rd;
  logic [1:0] resp;
  int err_count = 0, n_tests = 0, nf = 0, ni = 0, nt = 0;
  logic cnt_on = 1'b0;
  always #25 clk = ~clk;
  oss_top oss_top_i (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .primary_mode_config(pm),
    .initial_source_config(init_src), .ext_clock_range_config(range_cfg), .switch_monitor_config(swmon),
    .secondary_power_type_config(1'b0), .secondary_source_config(sec_src), .osc_out_function_config(1'b1),
    .osc_tick(osc_tick), .new_src_tick(new_src_tick), .new_src_ready(new_src_ready),
    .pll_locked(pll_locked), .clock_failure(clock_failure), .active_source(active_source),
    .starting_source(starting_source), .primary_kind(primary_kind), .pll_enable(pll_enable),
    .fosc_tick(fosc_tick), .instr_tick(instr_tick), .secondary_enable(secondary_enable),
    .secondary_high_power(hp), .ext_clock_range(ext_clock_range), .fast_rc_trim(trim),
    .osc_out_pin_o(pin_o), .osc_out_pin_oe(oe));
  oss_osc_model oss_osc_model_i (.clk(clk), .run(run), .lock_en(lock_en), .fail(fail),
    .osc_tick(osc_tick), .new_src_tick(new_src_tick), .new_src_ready(new_src_ready),
    .pll_locked(pll_locked), .clock_failure(clock_failure));
  always @(posedge clk)
  begin
    pin_q <= pin_o;
    if (cnt_on)
    begin
      nf <= nf + int'(fosc_tick);
      ni <= ni + int'(instr_tick);
      nt <= nt + int'(pin_o != pin_q);
    end
  end
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  // ==========================================================
  // Bus master; handshakes are judged just before the edge that takes them
  // Response readies stay high once raised, so back-to-back calls never toggle them
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    awaddr <= a; wdata <= d; wstrb <= 4'h3; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever
    begin
      @(negedge clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      resp = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh)
      begin
        break;
      end
    end
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    logic ah, rh;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever
    begin
      @(negedge clk);
      ah = arvalid && arready;
      rh = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
      if (rh)
      begin
        break;
      end
    end
  endtask : rdr
  task automatic wait_sw;
    for (int i = 0; i < 60; i++)
    begin
      rdr(OFS_OSC_CONTROL);
      if (rd[GO_BIT] === 1'b0) break;
    end
  endtask : wait_sw
  task automatic measure;
    nf <= 0; ni <= 0; nt <= 0; cnt_on <= 1'b1;
    repeat (200) @(posedge clk);
    cnt_on <= 1'b0;
    @(posedge clk);
  endtask : measure
  task automatic pulse_fail;
    fail <= 1'b1;
    @(posedge clk);
    fail <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse_fail
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done;
  end
  // ==========================================================
  // Scenarios
  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(active_source, 3'h7);
    chk({starting_source, primary_kind}, 5'h1F);
    chk(ext_clock_range, 2'h3);
    chk(oe, 1'b1);
    rdr(OFS_OSC_CONTROL); chk(rd, 32'h7700);
    rdr(OFS_CLOCK_DIVIDER); chk(rd, 32'h100);
    rdr(OFS_CONFIG_VIEW); chk(rd, 32'hC7F);
    rdr(8'h10); chk(resp, RESP_SLVERR);
    wr(8'h10, 32'hFFFF); chk(resp, RESP_SLVERR);
    wr(OFS_FAST_RC_TRIM, 32'h3F); rdr(OFS_FAST_RC_TRIM); chk(rd, 32'h3F);
    chk(trim, 6'h3F);
    measure; chk(nf >= 2 * ni - 2 && nf <= 2 * ni + 2 && ni > 20, 1);
    chk(nt >= nf - 2 && nt <= nf + 2 && nt > 40, 1);
    wr(OFS_CLOCK_DIVIDER, 32'h0);
    measure; chk(nf >= 95 && nf <= 105, 1);
    wr(OFS_OSC_CONTROL, 32'h701); rdr(OFS_OSC_CONTROL); chk(rd, 32'h7700);
    wr(OFS_OSC_CONTROL, 32'h001);
    repeat (30) @(posedge clk);
    rdr(OFS_OSC_CONTROL); chk(rd, 32'h7001);
    run <= 1'b1;
    repeat (20) @(posedge clk);
    chk(active_source, 3'h7);
    wait_sw; chk(rd, 32'h0000);
    chk({active_source, pll_enable}, 4'h0);
    wr(OFS_OSC_CONTROL, 32'h101);
    repeat (60) @(posedge clk);
    chk(active_source, 3'h0);
    lock_en <= 1'b1;
    wait_sw; chk(rd, 32'h1120);
    chk(pll_enable, 1'b1);
    pulse_fail;
    rdr(OFS_OSC_CONTROL); chk(rd, 32'h1128);
    wr(OFS_OSC_CONTROL, 32'h100); rdr(OFS_OSC_CONTROL); chk(rd, 32'h1120);
    wr(OFS_OSC_CONTROL, 32'h186); rdr(OFS_OSC_CONTROL); chk(rd, 32'h11A6);
    chk(secondary_enable, 1'b1);
    chk(hp, 1'b1);
    wr(OFS_OSC_CONTROL, 32'h100); rdr(OFS_OSC_CONTROL); chk(rd, 32'h11A0);
    chk(hp, 1'b0);
    wr(OFS_OSC_CONTROL, 32'h001);
    repeat (60) @(posedge clk);
    rdr(OFS_OSC_CONTROL); chk(rd, 32'h11A0);
    chk(active_source, 3'h1);
    // Second reset with switching disabled and a crystal primary
    sys_rst <= 1'b1; swmon <= 2'h2; pm <= PM_HIGH_SPEED_CRYSTAL; init_src <= SRC_PRIMARY;
    sec_src <= 1'b0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk({active_source, pll_enable, oe}, 5'h08);
    wr(OFS_OSC_CONTROL, 32'h305);
    repeat (60) @(posedge clk);
    pulse_fail;
    rdr(OFS_OSC_CONTROL); chk(rd, 32'h2204);
    chk(hp, 1'b0);
    chk(active_source, 3'h2);
    test_done;
  end
endmodule : oss_top_tb
